// [dv/irq_source_latch_props.sv]
// Checker for the source status and latch register pair
`timescale 1ns/10ps
module irq_source_latch_chk (
    input wire       core_clk,
    input wire       rst,
    input wire       vbus_input_monitor_good,
    input wire       overstress_detect,
    input wire       id_pin_open,
    input wire       id_resistor_range_c,
    input wire       id_resistor_range_b,
    input wire       id_resistor_range_a,
    input wire       b_session_valid,
    input wire [6:0] rise_enable,
    input wire [6:0] fall_enable,
    input wire       low_power_entry,
    input wire       serial_mode_entry,
    input wire       reg_read,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_rdata,
    input wire       reg_rvalid
);
    wire [6:0] s = {vbus_input_monitor_good, overstress_detect, id_pin_open, id_resistor_range_c,
        id_resistor_range_b, id_resistor_range_a, b_session_valid};
    reg  [6:0] ps;
    wire [6:0] ev = (s ^ ps) & ((s & rise_enable) | (~s & fall_enable));
    wire       rl = reg_read && reg_addr == 8'h84;
    // Previous levels start low after reset, so a source high at release counts as a rise
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ps <= 7'h00;
        end else begin
            ps <= s;
        end
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    AST_ANSWER: assert property (reg_read |=> reg_rvalid) else $error("no answer");
    AST_QUIET: assert property (!reg_read |=> !reg_rvalid) else $error("stray answer");
    AST_TOP_ZERO: assert property (reg_rvalid |-> !reg_rdata[7]) else $error("bit 7 set");
    AST_STATUS: assert property (reg_read && reg_addr == 8'h83 |=> reg_rdata == {1'b0, $past(s)})
        else $error("status wrong");
    AST_UNMAPPED: assert property (reg_read && reg_addr != 8'h83 && !rl |=> reg_rdata == 8'h00)
        else $error("unmapped nonzero");
    AST_SET: assert property (ev != 7'h00 ##1 rl |=> (reg_rdata[6:0] & $past(ev, 2)) == $past(ev, 2))
        else $error("event lost");
    AST_READ_CLR: assert property (rl && ev == 7'h00 ##1 rl && ev == 7'h00 |=> reg_rdata == 8'h00)
        else $error("read no clear");
    AST_LP_CLR: assert property (low_power_entry && ev == 7'h00 ##1 rl |=> reg_rdata == 8'h00)
        else $error("low power no clear");
    AST_SER_CLR: assert property (serial_mode_entry && ev == 7'h00 ##1 rl |=> reg_rdata == 8'h00)
        else $error("serial no clear");
    cover property (rl ##1 rl);
    cover property (low_power_entry);
    cover property (serial_mode_entry);
    cover property (rl && ev != 7'h00);
endmodule // irq_source_latch_chk
bind irq_source_latch irq_source_latch_chk chk (
    .core_clk                (core_clk),
    .rst                     (rst),
    .vbus_input_monitor_good (vbus_input_monitor_good),
    .overstress_detect       (overstress_detect),
    .id_pin_open             (id_pin_open),
    .id_resistor_range_c     (id_resistor_range_c),
    .id_resistor_range_b     (id_resistor_range_b),
    .id_resistor_range_a     (id_resistor_range_a),
    .b_session_valid         (b_session_valid),
    .rise_enable             (rise_enable),
    .fall_enable             (fall_enable),
    .low_power_entry         (low_power_entry),
    .serial_mode_entry       (serial_mode_entry),
    .reg_read                (reg_read),
    .reg_addr                (reg_addr),
    .reg_rdata               (reg_rdata),
    .reg_rvalid              (reg_rvalid)
);

// [dv/irq_source_latch_test.sv]
// Testbench for the source status and latch register pair
`timescale 1ns/10ps
module irq_source_latch_test;
    logic       core_clk          = 1'b0;
    logic       rst               = 1'b1;
    logic       low_power_entry   = 1'b0;
    logic       serial_mode_entry = 1'b0;
    logic       reg_read;
    logic       reg_write;
    logic       reg_rvalid;
    logic [6:0] s                 = 7'h00;
    logic [6:0] rise_enable       = 7'h7F;
    logic [6:0] fall_enable       = 7'h7F;
    logic [7:0] reg_addr;
    logic [7:0] reg_wdata;
    logic [7:0] reg_rdata;
    logic [7:0] d;
    int         err_total         = 0;
    int         n_checks          = 0;

    always #5 core_clk = ~core_clk;

    irq_source_latch uut (
        .core_clk                (core_clk),
        .rst                     (rst),
        .vbus_input_monitor_good (s[6]),
        .overstress_detect       (s[5]),
        .id_pin_open             (s[4]),
        .id_resistor_range_c     (s[3]),
        .id_resistor_range_b     (s[2]),
        .id_resistor_range_a     (s[1]),
        .b_session_valid         (s[0]),
        .rise_enable             (rise_enable),
        .fall_enable             (fall_enable),
        .low_power_entry         (low_power_entry),
        .serial_mode_entry       (serial_mode_entry),
        .reg_read                (reg_read),
        .reg_write               (reg_write),
        .reg_addr                (reg_addr),
        .reg_wdata               (reg_wdata),
        .reg_rdata               (reg_rdata),
        .reg_rvalid              (reg_rvalid)
    );

    link_model lnk (
        .core_clk   (core_clk),
        .reg_rvalid (reg_rvalid),
        .reg_rdata  (reg_rdata),
        .reg_read   (reg_read),
        .reg_write  (reg_write),
        .reg_addr   (reg_addr),
        .reg_wdata  (reg_wdata)
    );

    task rd(input logic [7:0] a, input int n, input logic [7:0] e);
        lnk.acc(1'b0, a, n, d);
        n_checks++;
        if (d !== e) begin
            err_total++;
            $display("MISMATCH reg_rdata at %h exp %h got %h", a, e, d);
        end
    endtask

    task complete_run;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task step(input int n);
        repeat (n) @(negedge core_clk);
    endtask

    initial begin
        repeat (6) @(posedge core_clk);
        @(negedge core_clk) rst = 1'b0;
        rd(8'h83, 1, 8'h00);
        rd(8'h84, 1, 8'h00);
        for (int k = 0; k < 7; k++) begin
            s = 7'h01 << k;
            step(1);
            rd(8'h83, 1, {1'b0, s});
        end
        s = 7'h00;
        step(1);
        rd(8'h84, 1, 8'h7F);
        rd(8'h84, 2, 8'h00);
        // Change lands in the very cycle of the clearing read
        s = 7'h01;
        rd(8'h84, 1, 8'h00);
        rd(8'h84, 1, 8'h01);
        $display("end of status and latch test");
        rise_enable = 7'h55;
        fall_enable = 7'h0A;
        s = 7'h7F;
        step(1);
        s = 7'h00;
        step(1);
        rd(8'h84, 1, 8'h5E);
        rise_enable = 7'h7F;
        fall_enable = 7'h7F;
        for (int j = 0; j < 2; j++) begin
            s = ~s;
            step(2);
            low_power_entry   = (j == 1);
            serial_mode_entry = (j == 0);
            step(1);
            low_power_entry   = 1'b0;
            serial_mode_entry = 1'b0;
            rd(8'h84, 1, 8'h00);
        end
        s = ~s;
        step(1);
        lnk.acc(1'b1, 8'h84, 1, d);
        rd(8'h84, 1, 8'h7F);
        rd(8'h85, 1, 8'h00);
        // Falling events in the very cycle of a low power clear must survive it
        s = 7'h00;
        low_power_entry = 1'b1;
        step(1);
        low_power_entry = 1'b0;
        rd(8'h84, 1, 8'h7F);
        $display("end of mask, clear and write test");
        complete_run;
    end
endmodule // irq_source_latch_test

// [dv/link_model.sv]
// Link side model issuing register accesses
`timescale 1ns/10ps
module link_model (
    input  wire        core_clk,
    input  wire        reg_rvalid,
    input  wire  [7:0] reg_rdata,
    output logic       reg_read  = 1'b0,
    output logic       reg_write = 1'b0,
    output logic [7:0] reg_addr  = 8'h00,
    output logic [7:0] reg_wdata = 8'h00
);
    // Caller sits at a falling edge; answer is due exactly one cycle after taking
    task acc(input logic w, input logic [7:0] a, input int n, output logic [7:0] d);
        repeat (n) begin
            reg_read  = !w;
            reg_write = w;
            reg_addr  = a;
            reg_wdata = {8{w}};
            @(negedge core_clk);
            d = (reg_rvalid === 1'b1) ? reg_rdata : 8'hXX;
        end
        // Released lines show the inverse so stale values cannot pass
        reg_read  = 1'b0;
        reg_write = 1'b0;
        reg_addr  = ~a;
        reg_wdata = ~reg_wdata;
        // One idle cycle, so a following call never re-raises the strobe in the same step
        @(negedge core_clk);
    endtask
endmodule // link_model

// [src/irq_source_latch.v]
// Interrupt source status mirror and change latch register pair
//
// Notes on behaviour
// - Status register read returns the present unlatched level of each source.
// - Status bits: 6 vbus monitor, 5 overstress, 4 id open, 3..1 ranges, 0 session.
// - A latch bit sets on any unmasked change of its source signal.
// - Latch register uses the same bit positions as the status register.
// - Reading the latch register returns its bits, then clears every bit that sees no event in that cycle.
// - Entering low power mode clears every latch bit that sees no event in that cycle.
// - Entering serial mode clears every latch bit that sees no event in that cycle.
// - An event coinciding with a clearing read is kept, never lost.
`timescale 1ns/10ps
`include "irq_source_map.vh"

// ----------------------------------------------------------------------------
// Per-source event cell
// ----------------------------------------------------------------------------
// Holds the previous level of one source, qualifies its edges and keeps one sticky event bit
module source_event_cell #(
    parameter [0:0] LEVEL_RESET = 1'b0,
    parameter [0:0] LATCH_RESET = 1'b0
) (
    input  wire core_clk,
    input  wire rst,
    input  wire source_in,
    input  wire rise_allow,
    input  wire fall_allow,
    input  wire clear_all,
    output reg  latch_bit
);

reg  source_prev;
reg  next_latch_bit;
wire went_high;
wire went_low;
wire event_seen;

// Previous level starts low, so a source already high at release counts as a rise
always @(posedge core_clk or posedge rst) begin
    if (rst) begin
        source_prev <= LEVEL_RESET;
    end else begin
        source_prev <= source_in;
    end
end

assign went_high = source_in & ~source_prev;
assign went_low  = ~source_in & source_prev;

assign event_seen = (went_high & rise_allow) | (went_low & fall_allow);

always @* begin
    next_latch_bit = latch_bit;
    if (clear_all) begin
        next_latch_bit = 1'b0;
    end
    // set wins clear
    // Set is applied last so an event in the clearing cycle is never lost
    if (event_seen) begin
        next_latch_bit = 1'b1;
    end
end

always @(posedge core_clk or posedge rst) begin
    if (rst) begin
        latch_bit <= LATCH_RESET;
    end else begin
        latch_bit <= next_latch_bit;
    end
end

endmodule // source_event_cell

// ----------------------------------------------------------------------------
// Register pair top
// ----------------------------------------------------------------------------
module irq_source_latch (
    input  wire       core_clk,
    input  wire       rst,
    input  wire       vbus_input_monitor_good,
    input  wire       overstress_detect,
    input  wire       id_pin_open,
    input  wire       id_resistor_range_c,
    input  wire       id_resistor_range_b,
    input  wire       id_resistor_range_a,
    input  wire       b_session_valid,
    input  wire [6:0] rise_enable,
    input  wire [6:0] fall_enable,
    input  wire       low_power_entry,
    input  wire       serial_mode_entry,
    input  wire       reg_read,
    input  wire       reg_write,
    input  wire [7:0] reg_addr,
    input  wire [7:0] reg_wdata,
    output reg  [7:0] reg_rdata,
    output reg        reg_rvalid
);

// ----------------------------------------------------------------------------
// Source levels and clear conditions
// ----------------------------------------------------------------------------
localparam [6:0] LEVEL_RESET = `SRC_STATUS_RESET;
localparam [6:0] LATCH_RESET = `SRC_LATCH_RESET;

wire [6:0] interrupt_source_status;
wire [6:0] interrupt_source_latch;
wire       latch_read;
wire       latch_clear;

assign interrupt_source_status = {vbus_input_monitor_good, overstress_detect, id_pin_open,
                                  id_resistor_range_c, id_resistor_range_b, id_resistor_range_a,
                                  b_session_valid};

assign latch_read = reg_read && (reg_addr == `SRC_LATCH_ADDR);

assign latch_clear = latch_read || low_power_entry || serial_mode_entry;

// ----------------------------------------------------------------------------
// Latch cells, one per source
// ----------------------------------------------------------------------------
// same positions as status
source_event_cell #(
    .LEVEL_RESET (LEVEL_RESET[`BIT_B_SESSION]),
    .LATCH_RESET (LATCH_RESET[`BIT_B_SESSION])
) session_cell (
    .core_clk   (core_clk),
    .rst        (rst),
    .source_in  (interrupt_source_status[`BIT_B_SESSION]),
    .rise_allow (rise_enable[`BIT_B_SESSION]),
    .fall_allow (fall_enable[`BIT_B_SESSION]),
    .clear_all  (latch_clear),
    .latch_bit  (interrupt_source_latch[`BIT_B_SESSION])
);

source_event_cell #(
    .LEVEL_RESET (LEVEL_RESET[`BIT_ID_RANGE_A]),
    .LATCH_RESET (LATCH_RESET[`BIT_ID_RANGE_A])
) range_a_cell (
    .core_clk   (core_clk),
    .rst        (rst),
    .source_in  (interrupt_source_status[`BIT_ID_RANGE_A]),
    .rise_allow (rise_enable[`BIT_ID_RANGE_A]),
    .fall_allow (fall_enable[`BIT_ID_RANGE_A]),
    .clear_all  (latch_clear),
    .latch_bit  (interrupt_source_latch[`BIT_ID_RANGE_A])
);

source_event_cell #(
    .LEVEL_RESET (LEVEL_RESET[`BIT_ID_RANGE_B]),
    .LATCH_RESET (LATCH_RESET[`BIT_ID_RANGE_B])
) range_b_cell (
    .core_clk   (core_clk),
    .rst        (rst),
    .source_in  (interrupt_source_status[`BIT_ID_RANGE_B]),
    .rise_allow (rise_enable[`BIT_ID_RANGE_B]),
    .fall_allow (fall_enable[`BIT_ID_RANGE_B]),
    .clear_all  (latch_clear),
    .latch_bit  (interrupt_source_latch[`BIT_ID_RANGE_B])
);

source_event_cell #(
    .LEVEL_RESET (LEVEL_RESET[`BIT_ID_RANGE_C]),
    .LATCH_RESET (LATCH_RESET[`BIT_ID_RANGE_C])
) range_c_cell (
    .core_clk   (core_clk),
    .rst        (rst),
    .source_in  (interrupt_source_status[`BIT_ID_RANGE_C]),
    .rise_allow (rise_enable[`BIT_ID_RANGE_C]),
    .fall_allow (fall_enable[`BIT_ID_RANGE_C]),
    .clear_all  (latch_clear),
    .latch_bit  (interrupt_source_latch[`BIT_ID_RANGE_C])
);

source_event_cell #(
    .LEVEL_RESET (LEVEL_RESET[`BIT_ID_OPEN]),
    .LATCH_RESET (LATCH_RESET[`BIT_ID_OPEN])
) id_open_cell (
    .core_clk   (core_clk),
    .rst        (rst),
    .source_in  (interrupt_source_status[`BIT_ID_OPEN]),
    .rise_allow (rise_enable[`BIT_ID_OPEN]),
    .fall_allow (fall_enable[`BIT_ID_OPEN]),
    .clear_all  (latch_clear),
    .latch_bit  (interrupt_source_latch[`BIT_ID_OPEN])
);

source_event_cell #(
    .LEVEL_RESET (LEVEL_RESET[`BIT_OVERSTRESS]),
    .LATCH_RESET (LATCH_RESET[`BIT_OVERSTRESS])
) overstress_cell (
    .core_clk   (core_clk),
    .rst        (rst),
    .source_in  (interrupt_source_status[`BIT_OVERSTRESS]),
    .rise_allow (rise_enable[`BIT_OVERSTRESS]),
    .fall_allow (fall_enable[`BIT_OVERSTRESS]),
    .clear_all  (latch_clear),
    .latch_bit  (interrupt_source_latch[`BIT_OVERSTRESS])
);

source_event_cell #(
    .LEVEL_RESET (LEVEL_RESET[`BIT_VBUS_MONITOR]),
    .LATCH_RESET (LATCH_RESET[`BIT_VBUS_MONITOR])
) vbus_monitor_cell (
    .core_clk   (core_clk),
    .rst        (rst),
    .source_in  (interrupt_source_status[`BIT_VBUS_MONITOR]),
    .rise_allow (rise_enable[`BIT_VBUS_MONITOR]),
    .fall_allow (fall_enable[`BIT_VBUS_MONITOR]),
    .clear_all  (latch_clear),
    .latch_bit  (interrupt_source_latch[`BIT_VBUS_MONITOR])
);

// ----------------------------------------------------------------------------
// Register read port
// ----------------------------------------------------------------------------
// writes are ignored; bit 7 always zero
// Both registers are read-only, so the write strobe and write data are left unread
always @(posedge core_clk or posedge rst) begin
    if (rst) begin
        reg_rdata  <= 8'h00;
        reg_rvalid <= 1'b0;
    end else begin
        reg_rvalid <= reg_read;
        if (reg_read) begin
            case (reg_addr)
                `SRC_STATUS_ADDR: reg_rdata <= {1'b0, interrupt_source_status};
                `SRC_LATCH_ADDR:  reg_rdata <= {1'b0, interrupt_source_latch};
                default:          reg_rdata <= 8'h00;
            endcase
        end
    end
end

endmodule // irq_source_latch

// [src/irq_source_map.vh]
// Register offsets, field positions and reset values of the interrupt source status and latch registers
`ifndef IRQ_SOURCE_MAP_VH
`define IRQ_SOURCE_MAP_VH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define SRC_STATUS_ADDR    8'h83
`define SRC_LATCH_ADDR     8'h84

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define BIT_B_SESSION      0
`define BIT_ID_RANGE_A     1
`define BIT_ID_RANGE_B     2
`define BIT_ID_RANGE_C     3
`define BIT_ID_OPEN        4
`define BIT_OVERSTRESS     5
`define BIT_VBUS_MONITOR   6
`define SRC_COUNT          7

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define SRC_STATUS_RESET   7'h00
`define SRC_LATCH_RESET    7'h00

`endif
